// ---- design/plc_cluster.v ----
// Programmable logic cluster: eight logic cells with carry, cascade and
// shared control lines, configured over an Avalon-MM slave.
// Assumes data, carry and cascade inputs come from logic on the same clock;
// the four control line pins come from outside and are synchronised.
`timescale 1ns/1ps
`include "plc_consts.vh"

module plc_cluster (
  input wire clock,
  input wire rstn,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire cluster_ctrl_one,
  input wire cluster_ctrl_two,
  input wire cluster_clk_one,
  input wire cluster_clk_two,
  input wire [31:0] data_in,
  input wire carry_in,
  input wire cascade_in,
  input wire [7:0] tri_enable,
  output wire [7:0] cell_output,
  output wire carry_out,
  output wire cascade_out,
  output wire tri_bus
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus and configuration store

  reg ack;
  reg [`PLC_CTRL_W-1:0] ctrl;
  reg [`PLC_CFG_W-1:0] cell_cfg [0:`PLC_CELLS-1];
  reg [7:0] cell_q;
  reg [3:0] pin_meta;
  reg [3:0] pin_sync;
  reg [3:0] line_prev;
  wire [3:0] line;
  wire [8:0] carry_chain;
  wire [8:0] casc_chain;
  wire run;
  wire bus_wr;
  wire cell_hit;
  wire [2:0] cell_idx;
  wire [8:0] tri_seen;
  wire [8:0] tri_clash;
  wire [8:0] tri_pick;
  wire [31:0] status_word;

  // One wait state on every access; both directions finish on the ack edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign bus_wr = avs_write & ack;
  assign run = ctrl[`PLC_CTRL_RUN];
  assign cell_hit = (avs_address >= `PLC_REG_CELL_BASE) &&
                    (avs_address <= `PLC_REG_CELL_LAST) &&
                    (avs_address[1:0] == 2'h0);
  assign cell_idx = avs_address[4:2];
  assign status_word = {17'h00000, tri_bus, cascade_out, carry_out, line,
                        cell_q};

  always @(posedge clock) begin
    if (!rstn) begin
      ack <= 1'b0;
      avs_readdata <= 32'h00000000;
      ctrl <= `PLC_CTRL_RESET;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
      if (avs_read && !ack) begin
        if (avs_address == `PLC_REG_CTRL)
          avs_readdata <= {23'h000000, ctrl};
        else if (avs_address == `PLC_REG_STATUS)
          avs_readdata <= status_word;
        else if (cell_hit)
          avs_readdata <= {4'h0, cell_cfg[cell_idx]};
        else
          avs_readdata <= 32'h00000000;
      end
      if (bus_wr && avs_address == `PLC_REG_CTRL)
        ctrl <= avs_writedata[`PLC_CTRL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared control lines

  // Pins are asynchronous to the cluster clock, so two flops each
  // Clear and load lines read asserted for two cycles after reset; run is low
  always @(posedge clock) begin
    if (!rstn) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      line_prev <= 4'h0;
    end else begin
      pin_meta <= {cluster_clk_two, cluster_clk_one, cluster_ctrl_two,
                   cluster_ctrl_one};
      pin_sync <= pin_meta;
      line_prev <= line;
    end
  end

  genvar k;
  generate
    for (k = 0; k < `PLC_LINES; k = k + 1) begin : g_line
      // Logic-sourced line comes from the cell of the same index
      assign line[k] = (ctrl[`PLC_CTRL_SRC_LSB+k] ? cell_output[k] :
                        pin_sync[k]) ^ ctrl[`PLC_CTRL_INV_LSB+k];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Logic cells

  assign carry_chain[0] = carry_in;
  assign casc_chain[0] = cascade_in;

  genvar i;
  generate
    for (i = 0; i < `PLC_CELLS; i = i + 1) begin : g_cell
      wire [27:0] cfg;
      wire [15:0] lut;
      wire [1:0] mode;
      wire [1:0] fft;
      wire [2:0] amode;
      wire [3:0] d;
      wire cin;
      wire cas;
      wire [3:0] idx4;
      wire [2:0] idx3;
      wire lut4;
      wire lo3;
      wire hi3;
      wire merged;
      wire ld_mux;
      wire clk_edge;
      wire pre_merge;
      reg n_clr;
      reg n_pre;
      reg n_load;
      reg comb;
      reg cout;
      reg casout;
      reg dval;
      reg next_q;

      assign cfg = cell_cfg[i];
      assign lut = cfg[`PLC_CFG_LUT_LSB+15:`PLC_CFG_LUT_LSB];
      assign mode = cfg[`PLC_CFG_MODE_LSB+1:`PLC_CFG_MODE_LSB];
      assign fft = cfg[`PLC_CFG_FF_LSB+1:`PLC_CFG_FF_LSB];
      assign amode = cfg[`PLC_CFG_ASYNC_LSB+2:`PLC_CFG_ASYNC_LSB];
      assign d = data_in[4*i+3:4*i];
      assign cin = carry_chain[i];
      assign cas = casc_chain[i];

      assign idx4 = {cfg[`PLC_CFG_CSEL] ? cin : d[3], d[2:0]};
      assign lut4 = lut[idx4];
      // Counter tables see register feedback in place of a data input
      assign idx3 = (mode == `PLC_MODE_ARITH) ? {cin, d[1:0]} :
                    {cin, d[1], cell_q[i]};
      assign lo3 = lut[{1'b0, idx3}];
      assign hi3 = lut[{1'b1, idx3}];
      assign pre_merge = lo_or_4(mode, lut4, lo3);
      // OR chaining is AND with inverted operands and result
      assign merged = cfg[`PLC_CFG_CASC_OR] ? ~(~pre_merge & ~cas) :
                      (pre_merge & cas);
      // Load select d2 wins over counting; the load value is d0
      assign ld_mux = d[2] ? d[0] : lo3;

      always @* begin
        comb = lut4;
        cout = cin;
        casout = cfg[`PLC_CFG_CASC_EN] ? merged : lut4;
        dval = lut4;
        case (mode)
          `PLC_MODE_NORMAL: begin
            comb = cfg[`PLC_CFG_CASC_EN] ? merged : lut4;
            cout = cin;
          end
          `PLC_MODE_ARITH: begin
            comb = cfg[`PLC_CFG_CASC_EN] ? merged : lo3;
            casout = cfg[`PLC_CFG_CASC_EN] ? merged : lo3;
            cout = hi3;
            dval = lo3;
          end
          `PLC_MODE_UPDN: begin
            comb = lo3;
            casout = cas;
            cout = hi3;
            dval = ld_mux;
          end
          `PLC_MODE_CLRCNT: begin
            comb = lo3;
            casout = 1'b1;
            cout = hi3;
            dval = ld_mux & ~cas;
          end
          default: begin
            comb = lut4;
          end
        endcase
      end

      // Controls are active low after inversion; unused ones sit high
      always @* begin
        n_clr = 1'b1;
        n_pre = 1'b1;
        n_load = 1'b1;
        case (amode)
          `PLC_AS_CLR: n_clr = line[1];
          `PLC_AS_PRE: n_pre = line[1];
          `PLC_AS_CLRPRE: begin
            n_pre = line[0];
            n_clr = line[1];
          end
          `PLC_AS_LDCLR: begin
            n_load = line[0];
            n_clr = line[1];
          end
          `PLC_AS_LDPRE: begin
            n_load = line[0];
            n_pre = line[1];
          end
          `PLC_AS_LD: n_load = line[0];
          default: begin
            n_clr = 1'b1;
          end
        endcase
      end

      // Register clocks are sampled edges, so they must run below half clock
      assign clk_edge = cfg[`PLC_CFG_CLKSEL] ? (line[3] & ~line_prev[3]) :
                        (line[2] & ~line_prev[2]);

      always @* begin
        next_q = cell_q[i];
        case (fft)
          `PLC_FF_D: next_q = dval;
          `PLC_FF_T: next_q = cell_q[i] ^ dval;
          `PLC_FF_JK: next_q = (dval & ~cell_q[i]) | (~d[3] & cell_q[i]);
          `PLC_FF_SR: next_q = dval | (~d[3] & cell_q[i]);
          default: next_q = dval;
        endcase
        // Counters always use plain D loading of the computed value
        if (mode != `PLC_MODE_NORMAL)
          next_q = dval;
      end

      // Clear wins over load, load over preset, all over the clock edge
      always @(posedge clock) begin
        if (!rstn)
          cell_q[i] <= 1'b0;
        else if (run) begin
          if (!n_clr)
            cell_q[i] <= 1'b0;
          else if (!n_load)
            cell_q[i] <= d[3];
          else if (!n_pre)
            cell_q[i] <= 1'b1;
          else if (clk_edge)
            cell_q[i] <= next_q;
        end
      end

      // Writes are refused while running, so no cell sees a half-built table
      always @(posedge clock) begin
        if (!rstn)
          cell_cfg[i] <= `PLC_CFG_RESET;
        else if (bus_wr && cell_hit && cell_idx == i && !run)
          cell_cfg[i] <= avs_writedata[`PLC_CFG_W-1:0];
      end

      assign cell_output[i] = cfg[`PLC_CFG_REGOUT] ? cell_q[i] :
                              comb;
      assign carry_chain[i+1] = cout;
      assign casc_chain[i+1] = casout;
    end
  endgenerate

  assign carry_out = carry_chain[8];
  assign cascade_out = casc_chain[8];

  ////////////////////////////////////////////////////////////////////////////
  // Emulated internal tri-state bus

  // Enables ripple upward: an enable above one already seen is contention
  assign tri_seen[0] = 1'b0;
  assign tri_clash[0] = 1'b0;
  assign tri_pick[0] = 1'b0;

  genvar t;
  generate
    for (t = 0; t < `PLC_CELLS; t = t + 1) begin : g_tri
      assign tri_seen[t+1] = tri_seen[t] | tri_enable[t];
      assign tri_clash[t+1] = tri_clash[t] | (tri_seen[t] & tri_enable[t]);
      assign tri_pick[t+1] = tri_pick[t] | (tri_enable[t] & cell_output[t]);
    end
  endgenerate

  assign tri_bus = !tri_seen[8] ? 1'b1 : tri_clash[8] ? 1'b0 :
                   tri_pick[8];

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Pre-merge value of a cell: full table in normal mode, sum table otherwise
  function lo_or_4;
    input [1:0] m;
    input a4;
    input a3;
    begin
      lo_or_4 = (m == `PLC_MODE_NORMAL) ? a4 : a3;
    end
  endfunction

endmodule

// ---- design/plc_consts.vh ----
// Constants for the programmable logic cluster: register map, config fields.
// Assumes byte addressing on the register bus and 32-bit data words.
`ifndef PLC_CONSTS_VH
`define PLC_CONSTS_VH

`define PLC_CELLS 8
`define PLC_LINES 4
`define PLC_ADDR_W 8
`define PLC_DATA_W 32

// Register byte offsets
`define PLC_REG_CTRL 8'h00
`define PLC_REG_STATUS 8'h04
`define PLC_REG_CELL_BASE 8'h40
`define PLC_REG_CELL_LAST 8'h5C

// Cluster control register fields
`define PLC_CTRL_INV_LSB 0
`define PLC_CTRL_SRC_LSB 4
`define PLC_CTRL_RUN 8
`define PLC_CTRL_W 9
`define PLC_CTRL_RESET 9'h000

// Cell configuration fields
`define PLC_CFG_LUT_LSB 0
`define PLC_CFG_MODE_LSB 16
`define PLC_CFG_FF_LSB 18
`define PLC_CFG_CSEL 20
`define PLC_CFG_REGOUT 21
`define PLC_CFG_CASC_EN 22
`define PLC_CFG_CASC_OR 23
`define PLC_CFG_ASYNC_LSB 24
`define PLC_CFG_CLKSEL 27
`define PLC_CFG_W 28
`define PLC_CFG_RESET 28'h0000000

// Operating modes
`define PLC_MODE_NORMAL 2'h0
`define PLC_MODE_ARITH 2'h1
`define PLC_MODE_UPDN 2'h2
`define PLC_MODE_CLRCNT 2'h3

// Flip-flop types
`define PLC_FF_D 2'h0
`define PLC_FF_T 2'h1
`define PLC_FF_JK 2'h2
`define PLC_FF_SR 2'h3

// Clear / preset / load modes
`define PLC_AS_NONE 3'h0
`define PLC_AS_CLR 3'h1
`define PLC_AS_PRE 3'h2
`define PLC_AS_CLRPRE 3'h3
`define PLC_AS_LDCLR 3'h4
`define PLC_AS_LDPRE 3'h5
`define PLC_AS_LD 3'h6

`endif

// ---- tb/plc_cluster_monitor.sv ----
// Port checker for the cluster: bus handshake, tri-state bus, status.
// Assumes it is bound to every plc_cluster instance.
`timescale 1ns/1ps
module plc_cluster_monitor (
  input wire clock,
  input wire rstn,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [7:0] tri_enable,
  input wire [7:0] cell_output,
  input wire carry_out,
  input wire cascade_out,
  input wire tri_bus
);
  wire req = avs_read | avs_write;
  wire [2:0] chain = {tri_bus, cascade_out, carry_out};
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////////
  wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state longer than one cycle");
  idle_nowait_a: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest without request");
  tri_idle_a: assert property (tri_enable == 8'h00 |-> tri_bus)
    else $error("undriven bus not high");
  tri_clash_a: assert property ($countones(tri_enable) > 1 |-> !tri_bus)
    else $error("contended bus not low");
  tri_pass_a: assert property ($onehot(tri_enable) |->
    tri_bus == |(tri_enable & cell_output))
    else $error("single driver not passed");
  stat_read_a: assert property (avs_read && avs_waitrequest &&
    avs_address == 8'h04 |=> avs_readdata[14:12] == $past(chain)
    && avs_readdata[31:15] == 17'h0)
    else $error("status chain bits wrong");
  hole_read_a: assert property (avs_read && avs_waitrequest &&
    avs_address == 8'h10 |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  rst_clear_a: assert property (disable iff (1'b0)
    !rstn |=> avs_readdata == 32'h0)
    else $error("read data not cleared by reset");
  cover property (avs_write && !avs_waitrequest);
  cover property ($countones(tri_enable) > 1);
  cover property ($rose(cell_output[0]));
endmodule

bind plc_cluster plc_cluster_monitor plc_cluster_monitor_i (.clock, .rstn,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .tri_enable, .cell_output, .carry_out, .cascade_out, .tri_bus);

// ---- tb/plc_fabric.sv ----
// Upstream neighbour of the cluster: data lines and chain ends.
// Assumes the bench freezes it with hold whenever results are compared.
`timescale 1ns/1ps
module plc_fabric (
  input wire clock,
  input wire rstn,
  input wire hold,
  output reg [31:0] data_in,
  output reg carry_in,
  output reg cascade_in
);
  integer seed;
  reg [31:0] r;
  initial begin
    seed = 1;
    data_in = 32'h0;
    carry_in = 1'b0;
    cascade_in = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////
  // Chain ends take new random values on every cycle that hold is low, so a
  // stale value is never mistaken for a correct one
  always @(posedge clock) begin
    if (!hold) begin
      r = $random(seed);
      data_in <= $random(seed);
      carry_in <= r[0];
      cascade_in <= r[1];
    end
  end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the logic cluster, random data from the fabric.
// Assumes plc_consts.vh is on the include path.
`timescale 1ns/1ps
`include "plc_consts.vh"
module testbench;
  reg clock, rstn, avs_read, avs_write, hold;
  reg [7:0] avs_address, tri_enable, e;
  reg [31:0] avs_writedata, rd, r;
  reg cluster_ctrl_one, cluster_ctrl_two, cluster_clk_one, cluster_clk_two;
  wire [31:0] avs_readdata, data_in;
  wire avs_waitrequest, carry_in, cascade_in, carry_out, cascade_out, tri_bus;
  wire [7:0] cell_output;
  reg [15:0] lut [0:7];
  reg [8:0] s;
  reg c, q;
  integer error_cnt, total_checks, seed, cyc, i, n, m;
  plc_cluster plc_cluster_i (.clock, .rstn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .cluster_ctrl_one, .cluster_ctrl_two, .cluster_clk_one, .cluster_clk_two,
    .data_in, .carry_in, .cascade_in, .tri_enable, .cell_output, .carry_out,
    .cascade_out, .tri_bus);
  plc_fabric plc_fabric_i (.clock, .rstn, .hold, .data_in, .carry_in,
    .cascade_in);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Request stands until waitrequest is sampled low at a rising edge; the
  // leading edge keeps a release and the next request in separate steps
  task bus(input wr, input [7:0] ad, input [31:0] wd);
    begin
      @(posedge clock);
      avs_address <= ad;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0)
        @(posedge clock);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task chk_reg(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t reg %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chk_pin(input [7:0] got, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t pins %h exp %h", $time, got, exp);
      end
    end
  endtask
  task step;
    begin
      @(posedge clock);
      r = $random(seed);
      hold <= 1'b0;
      tri_enable <= r[7:0];
      @(posedge clock);
      hold <= 1'b1;
      @(negedge clock);
    end
  endtask
  // Cell 0 setups: D, load, T, JK, SR, counters, then the clear/preset modes
  function [31:0] cfg_of(input [3:0] k);
    begin
      case (k)
        4'h1: cfg_of = 32'h0620AAAA;
        4'h2: cfg_of = 32'h0024AAAA;
        4'h3: cfg_of = 32'h0028AAAA;
        4'h4: cfg_of = 32'h002CAAAA;
        4'h5: cfg_of = 32'h0023005A;
        4'h6: cfg_of = 32'h0822005A;
        4'h7: cfg_of = 32'h0320AAAA;
        4'h8: cfg_of = 32'h0420AAAA;
        4'h9: cfg_of = 32'h0520AAAA;
        4'hA: cfg_of = 32'h0120AAAA;
        4'hB: cfg_of = 32'h0220AAAA;
        default: cfg_of = 32'h0020AAAA;
      endcase
    end
  endfunction
  function exp_q(input [3:0] k, input qo, input [3:0] d, input ci,
    input ca);
    begin
      case (k)
        4'h1: exp_q = d[3];
        4'h2: exp_q = qo ^ d[0];
        4'h3: exp_q = (d[0] & ~qo) | (~d[3] & qo);
        4'h4: exp_q = d[0] | (~d[3] & qo);
        4'h5: exp_q = (d[2] ? d[0] : qo ^ ci) & ~ca;
        4'h6: exp_q = d[2] ? d[0] : qo ^ ci;
        4'h7, 4'h9, 4'hB: exp_q = 1'b1;
        4'h8, 4'hA: exp_q = 1'b0;
        default: exp_q = d[0];
      endcase
    end
  endfunction
  task close_out;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, avs_read, avs_write, cluster_clk_one, cluster_clk_two} = 5'h00;
    {hold, cluster_ctrl_one, cluster_ctrl_two} = 3'h7;
    {avs_address, tri_enable, avs_writedata} = 48'h0;
    {error_cnt, total_checks, cyc} = 96'h0;
    seed = 1;
    q = 1'b0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    bus(1'b0, `PLC_REG_CTRL, 32'h0);
    chk_reg(rd, 32'h0);
    bus(1'b1, `PLC_REG_STATUS, 32'hFFFFFFFF);
    bus(1'b0, `PLC_REG_STATUS, 32'h0);
    chk_reg(rd & 32'hFFF, 32'h300);
    bus(1'b0, 8'h10, 32'h0);
    chk_reg(rd, 32'h0);
    $display("test 1 done");
    for (m = 0; m < 4; m = m + 1) begin
      for (i = 0; i < 8; i = i + 1) begin
        r = $random(seed);
        lut[i] = m == 1 ? r[15:0] | 16'hFBFF : r[15:0];
        lut[i] = m == 2 ? ~(r[15:0] | 16'hFBFF) : lut[i];
        lut[i] = m == 3 ? 16'hE896 : lut[i];
        r = m == 3 ? 32'h00010000 : {8'h00, m == 2, m != 0, 22'h000000};
        bus(1'b1, `PLC_REG_CELL_BASE + {i[5:0], 2'b00}, r | lut[i]);
      end
      for (n = 0; n < 20; n = n + 1) begin
        step;
        c = cascade_in;
        s = {1'b0, data_in[28], data_in[24], data_in[20], data_in[16],
          data_in[12], data_in[8], data_in[4], data_in[0]} + carry_in;
        for (i = 0; i < 8; i = i + 1) begin
          e[i] = lut[i][data_in[4 * i +: 4]];
          c = m == 2 ? e[i] | c : e[i] & c;
          s = s + {data_in[4 * i + 1], 1'b0} * (9'h1 << i) / 2;
        end
        if (m == 0)
          chk_pin(cell_output, e);
        if (m == 0)
          chk_pin({7'h0, carry_out}, {7'h0, carry_in});
        if (m == 1 || m == 2)
          chk_pin({7'h0, cascade_out}, {7'h0, c});
        if (m == 3)
          chk_pin(cell_output, s[7:0]);
        if (m == 3)
          chk_pin({7'h0, carry_out}, {7'h0, s[8]});
      end
      $display("test %0d done", m + 2);
    end
    for (m = 0; m < 12; m = m + 1) begin
      r = cfg_of(m[3:0]);
      bus(1'b1, `PLC_REG_CTRL, 32'h0);
      bus(1'b1, `PLC_REG_CELL_BASE, r);
      bus(1'b1, `PLC_REG_CTRL, m == 11 ? 32'h102 : 32'h100);
      bus(1'b1, `PLC_REG_CELL_BASE, 32'h0);
      bus(1'b0, `PLC_REG_CELL_BASE, 32'h0);
      chk_reg(rd, r);
      for (n = 0; n < 6; n = n + 1) begin
        step;
        @(posedge clock);
        cluster_ctrl_one <= !(m == 1 || m == 7);
        cluster_ctrl_two <= !(m >= 8 && m <= 10);
        cluster_clk_one <= m == 0 || (m >= 2 && m <= 5);
        cluster_clk_two <= m == 6;
        repeat (3) @(posedge clock);
        @(negedge clock);
        q = exp_q(m[3:0], q, data_in[3:0], carry_in, cascade_in);
        e = {7'h0, q};
        chk_pin(cell_output & 8'h01, e);
        @(posedge clock);
        cluster_ctrl_one <= 1'b1;
        cluster_ctrl_two <= 1'b1;
        cluster_clk_one <= 1'b0;
        cluster_clk_two <= 1'b0;
        repeat (3) @(posedge clock);
      end
      $display("test %0d done", m + 6);
    end
    close_out;
  end
endmodule
